// file: rtl/usbap_pkg.sv
// Purpose: Shared constants and types for the USB address and power control block
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes: Register index times four gives the byte address
package usbap_pkg;

  // Register indices (byte address is index times four)
  localparam logic [1:0] IDX_FUNC_ADDR = 2'h0;
  localparam logic [1:0] IDX_POWER = 2'h1;
  localparam logic [1:0] IDX_IRQ_STATUS = 2'h2;
  localparam logic [1:0] IDX_IRQ_MASK = 2'h3;
  localparam int NUM_REGS = 4;

  // Reset values
  localparam logic [7:0] RST_FUNC_ADDR = 8'h00;
  localparam logic [7:0] RST_POWER = 8'h20;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;

  // Power register fields
  localparam int PWR_ISO_WAIT = 7;
  localparam int PWR_SOFT_CONN = 6;
  localparam int PWR_RSVD_LO = 4;
  localparam logic [1:0] PWR_RSVD_VAL = 2'h2;
  localparam int PWR_RESET = 3;
  localparam int PWR_RESUME = 2;
  localparam int PWR_SUSPEND = 1;
  localparam int PWR_XCVR_PD = 0;

  // Interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_SUSPEND = 0;
  localparam int IRQ_BUS_RESET = 1;
  localparam int IRQ_ZERO_LEN = 2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Token seen by the link logic
  typedef struct packed {
    logic valid;
    logic is_in;
    logic iso;
    logic [6:0] addr;
  } usbap_token_t;

  // Transmit-side controls to the link logic
  typedef struct packed {
    logic send_packet;
    logic send_zero_len;
    logic addr_match;
  } usbap_tx_t;

  // Byte address to register index; valid only when mapped
  function automatic logic [2:0] usbap_decode(input logic [11:0] addr);
    logic [2:0] r;
    r = 3'h4;
    if (addr[11:4] == 8'h00 && addr[1:0] == 2'h0) begin
      r = {1'b0, addr[3:2]};
    end
    return r;
  endfunction : usbap_decode

endpackage : usbap_pkg

// file: rtl/usbap_axil.sv
// Purpose: AXI4-Lite slave front end producing register strobes
// Assumes: One write and one read outstanding at most
// Notes: Answer comes one cycle after the request is complete
`timescale 1ns/1ps
module usbap_axil #(
  parameter int AW = 12
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Write channels
  input wire logic [AW-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  // Read channels
  input wire logic [AW-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // Register side
  output logic wr_en_o,
  output logic [AW-1:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic [3:0] wr_strb_o,
  input wire logic wr_err_i,
  output logic rd_en_o,
  output logic [AW-1:0] rd_addr_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_err_i
);
  logic aw_hold_q;
  logic w_hold_q;
  logic ar_hold_q;

  assign wr_en_o = aw_hold_q & w_hold_q & ~bvalid_o;
  assign rd_en_o = ar_hold_q & ~rvalid_o;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      awready_o <= 1'b1;
      wready_o <= 1'b1;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_o <= 1'b0;
      bresp_o <= usbap_pkg::RESP_OKAY;
      wr_addr_o <= '0;
      wr_data_o <= '0;
      wr_strb_o <= '0;
    end else begin
      if (awvalid_i && awready_o) begin
        awready_o <= 1'b0;
        aw_hold_q <= 1'b1;
        wr_addr_o <= awaddr_i;
      end
      if (wvalid_i && wready_o) begin
        wready_o <= 1'b0;
        w_hold_q <= 1'b1;
        wr_data_o <= wdata_i;
        wr_strb_o <= wstrb_i;
      end
      if (wr_en_o) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_o <= 1'b1;
        bresp_o <= wr_err_i ? usbap_pkg::RESP_SLVERR : usbap_pkg::RESP_OKAY;
      end
      if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
        awready_o <= 1'b1;
        wready_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      arready_o <= 1'b1;
      ar_hold_q <= 1'b0;
      rvalid_o <= 1'b0;
      rresp_o <= usbap_pkg::RESP_OKAY;
      rdata_o <= '0;
      rd_addr_o <= '0;
    end else begin
      if (arvalid_i && arready_o) begin
        arready_o <= 1'b0;
        ar_hold_q <= 1'b1;
        rd_addr_o <= araddr_i;
      end
      if (rd_en_o) begin
        ar_hold_q <= 1'b0;
        rvalid_o <= 1'b1;
        rdata_o <= rd_err_i ? 32'h0000_0000 : rd_data_i;
        rresp_o <= rd_err_i ? usbap_pkg::RESP_SLVERR : usbap_pkg::RESP_OKAY;
      end
      if (rvalid_o && rready_i) begin
        rvalid_o <= 1'b0;
        arready_o <= 1'b1;
      end
    end
  end

endmodule : usbap_axil

// file: rtl/usbap_irq.sv
// Purpose: Sticky event status with mask and one level interrupt
// Assumes: Events are one-cycle pulses on the system clock
// Notes: A new event wins over a write-one clear in the same cycle
`timescale 1ns/1ps
module usbap_irq #(
  parameter int W = 3
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] event_i,
  input wire logic [W-1:0] clear_i,
  input wire logic mask_we_i,
  input wire logic [W-1:0] mask_i,
  output logic [W-1:0] status_o,
  output logic [W-1:0] mask_o,
  output logic irq_o
);
  logic [W-1:0] status_d;

  assign status_d = (status_o & ~clear_i) | event_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      status_o <= '0;
      mask_o <= usbap_pkg::RST_IRQ_MASK;
      irq_o <= 1'b0;
    end else begin
      status_o <= status_d;
      if (mask_we_i) begin
        mask_o <= mask_i;
      end
      irq_o <= |(status_d & (mask_we_i ? mask_i : mask_o));
    end
  end

endmodule : usbap_irq

// file: rtl/usbap_ctrl.sv
// Purpose: Function address and power/suspend/resume control of a dual-role USB controller
// Assumes: Link logic on the same clock; bus reset level arrives from the pin side
// Notes: Registers sit at four times their index on an AXI4-Lite bus
`timescale 1ns/1ps
module usbap_ctrl #(
  parameter int AW = 12
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  // AXI4-Lite slave
  input wire logic [AW-1:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [AW-1:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // Controller context
  input wire logic HOST_MODE_I,
  input wire logic INTR_REG_READ_I,
  // Link logic events
  input wire logic BUS_RESET_PIN_I,
  input wire logic SUSPEND_ENTRY_I,
  input wire logic SOF_SEEN_I,
  input wire logic TRANSMIT_PACKET_READY_I,
  input wire usbap_pkg::usbap_token_t TOKEN_I,
  // Link logic controls
  output usbap_pkg::usbap_tx_t TX_O,
  output logic [6:0] BUS_FUNCTION_ADDRESS_O,
  output logic DP_OE_O,
  output logic DM_OE_O,
  output logic BUS_RESET_DRIVE_O,
  output logic RESUME_DRIVE_O,
  output logic SUSPEND_O,
  output logic TRANSCEIVER_POWER_DOWN_O,
  // Interrupt
  output logic IRQ_O
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT_SOF = 3'h2,
    ST_ARMED = 3'h4
  } usbap_tx_state_t;

  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic wr_lane;
  logic wr_addr_reg;
  logic wr_pwr_reg;
  logic wr_sts_reg;
  logic wr_msk_reg;
  logic [7:0] wb;

  logic [6:0] func_addr_q;
  logic iso_sof_wait_q;
  logic soft_connect_q;
  logic host_reset_q;
  logic resume_q;
  logic suspend_q;
  logic suspend_d;
  logic xcvr_pd_q;
  logic bus_rst_meta_q;
  logic bus_rst_sync_q;
  logic bus_rst_prev_q;
  logic [7:0] power_rd;
  logic [2:0] irq_event;
  logic [2:0] irq_clear;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic token_match;
  logic zero_len_d;
  usbap_tx_state_t tx_state_q;
  usbap_tx_state_t tx_state_d;

  usbap_axil #(
    .AW(AW)
  ) u_axil (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESET_N_I),
    .awaddr_i(AWADDR_I),
    .awvalid_i(AWVALID_I),
    .awready_o(AWREADY_O),
    .wdata_i(WDATA_I),
    .wstrb_i(WSTRB_I),
    .wvalid_i(WVALID_I),
    .wready_o(WREADY_O),
    .bresp_o(BRESP_O),
    .bvalid_o(BVALID_O),
    .bready_i(BREADY_I),
    .araddr_i(ARADDR_I),
    .arvalid_i(ARVALID_I),
    .arready_o(ARREADY_O),
    .rdata_o(RDATA_O),
    .rresp_o(RRESP_O),
    .rvalid_o(RVALID_O),
    .rready_i(RREADY_I),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_strb_o(wr_strb),
    .wr_err_i(wr_idx[2]),
    .rd_en_o(rd_en),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_err_i(rd_idx[2])
  );

  // Register decode; only byte lane 0 carries data
  assign wr_idx = usbap_pkg::usbap_decode(12'(wr_addr));
  assign rd_idx = usbap_pkg::usbap_decode(12'(rd_addr));
  assign wr_lane = wr_en & wr_strb[0] & ~wr_idx[2];
  assign wr_addr_reg = wr_lane && wr_idx[1:0] == usbap_pkg::IDX_FUNC_ADDR;
  assign wr_pwr_reg = wr_lane && wr_idx[1:0] == usbap_pkg::IDX_POWER;
  assign wr_sts_reg = wr_lane && wr_idx[1:0] == usbap_pkg::IDX_IRQ_STATUS;
  assign wr_msk_reg = wr_lane && wr_idx[1:0] == usbap_pkg::IDX_IRQ_MASK;
  assign wb = wr_data[7:0];

  // Bus reset level comes from the pin side, so it is synchronised first
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      bus_rst_meta_q <= 1'b0;
      bus_rst_sync_q <= 1'b0;
      bus_rst_prev_q <= 1'b0;
    end else begin
      bus_rst_meta_q <= BUS_RESET_PIN_I;
      bus_rst_sync_q <= bus_rst_meta_q;
      bus_rst_prev_q <= bus_rst_sync_q;
    end
  end

  // Function address; bit 7 is not stored
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      func_addr_q <= usbap_pkg::RST_FUNC_ADDR[6:0];
    end else if (wr_addr_reg) begin
      func_addr_q <= wb[6:0];
    end
  end

  // Power register fields that are plain read/write in one or both modes
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      iso_sof_wait_q <= usbap_pkg::RST_POWER[usbap_pkg::PWR_ISO_WAIT];
      soft_connect_q <= usbap_pkg::RST_POWER[usbap_pkg::PWR_SOFT_CONN];
      host_reset_q <= usbap_pkg::RST_POWER[usbap_pkg::PWR_RESET];
      resume_q <= usbap_pkg::RST_POWER[usbap_pkg::PWR_RESUME];
      xcvr_pd_q <= usbap_pkg::RST_POWER[usbap_pkg::PWR_XCVR_PD];
    end else if (wr_pwr_reg) begin
      if (!HOST_MODE_I) begin
        iso_sof_wait_q <= wb[usbap_pkg::PWR_ISO_WAIT];
        soft_connect_q <= wb[usbap_pkg::PWR_SOFT_CONN];
      end else begin
        host_reset_q <= wb[usbap_pkg::PWR_RESET];
      end
      // Resume timing is software's job; hardware just drives while set
      resume_q <= wb[usbap_pkg::PWR_RESUME];
      xcvr_pd_q <= wb[usbap_pkg::PWR_XCVR_PD];
    end
  end

  // Suspend: entry in device mode or a host write of one sets it;
  // a set in the same cycle as a clear wins so no entry is lost
  always_comb begin
    suspend_d = suspend_q;
    if (INTR_REG_READ_I || (wr_pwr_reg && wb[usbap_pkg::PWR_RESUME])) begin
      suspend_d = 1'b0;
    end
    if (!HOST_MODE_I && SUSPEND_ENTRY_I) begin
      suspend_d = 1'b1;
    end
    if (HOST_MODE_I && wr_pwr_reg && wb[usbap_pkg::PWR_SUSPEND]) begin
      suspend_d = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      suspend_q <= usbap_pkg::RST_POWER[usbap_pkg::PWR_SUSPEND];
    end else begin
      suspend_q <= suspend_d;
    end
  end

  // Read view of the power register depends on the role
  always_comb begin
    power_rd = '0;
    power_rd[usbap_pkg::PWR_RSVD_LO +: 2] = usbap_pkg::PWR_RSVD_VAL;
    power_rd[usbap_pkg::PWR_RESUME] = resume_q;
    power_rd[usbap_pkg::PWR_SUSPEND] = suspend_q;
    power_rd[usbap_pkg::PWR_XCVR_PD] = xcvr_pd_q;
    if (HOST_MODE_I) begin
      power_rd[usbap_pkg::PWR_RESET] = host_reset_q;
    end else begin
      power_rd[usbap_pkg::PWR_ISO_WAIT] = iso_sof_wait_q;
      power_rd[usbap_pkg::PWR_SOFT_CONN] = soft_connect_q;
      power_rd[usbap_pkg::PWR_RESET] = bus_rst_sync_q;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_idx)
      3'h0: rd_data[7:0] = {1'b0, func_addr_q};
      3'h1: rd_data[7:0] = power_rd;
      3'h2: rd_data[2:0] = irq_status;
      3'h3: rd_data[2:0] = irq_mask;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Token matching applies only in device mode
  assign token_match = TOKEN_I.valid && !HOST_MODE_I && TOKEN_I.addr == func_addr_q;

  // Transmit sequencing; the SOF hold-off is for isochronous endpoints only
  always_comb begin
    tx_state_d = tx_state_q;
    zero_len_d = 1'b0;
    case (tx_state_q)
      ST_IDLE: begin
        if (TRANSMIT_PACKET_READY_I) begin
          tx_state_d = (iso_sof_wait_q && TOKEN_I.iso && !HOST_MODE_I)
                       ? ST_WAIT_SOF : ST_ARMED;
        end
      end
      ST_WAIT_SOF: begin
        if (token_match && TOKEN_I.is_in) begin
          zero_len_d = 1'b1;
        end else if (SOF_SEEN_I) begin
          tx_state_d = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (token_match && TOKEN_I.is_in) begin
          tx_state_d = ST_IDLE;
        end
      end
      default: tx_state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      tx_state_q <= ST_IDLE;
      TX_O <= '0;
    end else begin
      tx_state_q <= tx_state_d;
      TX_O.addr_match <= token_match;
      TX_O.send_zero_len <= zero_len_d;
      TX_O.send_packet <= tx_state_q == ST_ARMED && tx_state_d == ST_IDLE;
    end
  end

  // Drive pins from registered state
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      BUS_FUNCTION_ADDRESS_O <= '0;
      DP_OE_O <= 1'b0;
      DM_OE_O <= 1'b0;
      BUS_RESET_DRIVE_O <= 1'b0;
      RESUME_DRIVE_O <= 1'b0;
      SUSPEND_O <= 1'b0;
      TRANSCEIVER_POWER_DOWN_O <= 1'b0;
    end else begin
      BUS_FUNCTION_ADDRESS_O <= func_addr_q;
      // Host mode always drives; device mode waits for soft connect
      DP_OE_O <= HOST_MODE_I | soft_connect_q;
      DM_OE_O <= HOST_MODE_I | soft_connect_q;
      BUS_RESET_DRIVE_O <= HOST_MODE_I & host_reset_q;
      RESUME_DRIVE_O <= resume_q;
      SUSPEND_O <= suspend_q;
      TRANSCEIVER_POWER_DOWN_O <= xcvr_pd_q;
    end
  end

  // Events into the interrupt block
  assign irq_event[usbap_pkg::IRQ_SUSPEND] = suspend_d & ~suspend_q;
  assign irq_event[usbap_pkg::IRQ_BUS_RESET] = bus_rst_sync_q & ~bus_rst_prev_q;
  assign irq_event[usbap_pkg::IRQ_ZERO_LEN] = zero_len_d;
  assign irq_clear = wr_sts_reg ? wb[2:0] : 3'h0;

  usbap_irq #(
    .W(usbap_pkg::IRQ_W)
  ) u_irq (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESET_N_I),
    .event_i(irq_event),
    .clear_i(irq_clear),
    .mask_we_i(wr_msk_reg),
    .mask_i(wb[2:0]),
    .status_o(irq_status),
    .mask_o(irq_mask),
    .irq_o(IRQ_O)
  );

  // Checks
  property p_addr_top_zero;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    rd_en && rd_idx == 3'h0 |=> RVALID_O && RDATA_O[7] == 1'b0;
  endproperty
  a_addr_top_zero: assert property (p_addr_top_zero) else $error("address bit 7 read as one");

  property p_host_no_match;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    HOST_MODE_I |=> !TX_O.addr_match;
  endproperty
  a_host_no_match: assert property (p_host_no_match) else $error("match while in host mode");

  property p_host_reset_drive;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    HOST_MODE_I && wr_pwr_reg ##1 HOST_MODE_I |=> BUS_RESET_DRIVE_O == $past(wb[3], 2);
  endproperty
  a_host_reset_drive: assert property (p_host_reset_drive) else $error("reset drive wrong");

  property p_host_suspend_w1s;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    HOST_MODE_I && suspend_q && wr_pwr_reg && !wb[2] && !INTR_REG_READ_I |=> suspend_q;
  endproperty
  a_host_suspend_w1s: assert property (p_host_suspend_w1s) else $error("zero write cleared");

  property p_pwrdn;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    wr_pwr_reg |-> ##2 TRANSCEIVER_POWER_DOWN_O == $past(wb[0], 2);
  endproperty
  a_pwrdn: assert property (p_pwrdn) else $error("power down not following write");

  property p_wait_sof;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    tx_state_q == ST_WAIT_SOF |=> !TX_O.send_packet;
  endproperty
  a_wait_sof: assert property (p_wait_sof) else $error("packet sent before SOF");

  property p_zero_len;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    tx_state_q == ST_WAIT_SOF && token_match && TOKEN_I.is_in |=> TX_O.send_zero_len;
  endproperty
  a_zero_len: assert property (p_zero_len) else $error("zero-length packet missing");

  property p_non_iso;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    tx_state_q == ST_IDLE && TRANSMIT_PACKET_READY_I && !TOKEN_I.iso |=> tx_state_q == ST_ARMED;
  endproperty
  a_non_iso: assert property (p_non_iso) else $error("non-iso packet held");

  property p_soft_conn;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    !HOST_MODE_I && !soft_connect_q |=> !DP_OE_O && !DM_OE_O;
  endproperty
  a_soft_conn: assert property (p_soft_conn) else $error("lines driven while disconnected");

  property p_dev_reset_view;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    !HOST_MODE_I && rd_en && rd_idx == 3'h1 |=> RDATA_O[3] == $past(bus_rst_sync_q);
  endproperty
  a_dev_reset_view: assert property (p_dev_reset_view) else $error("bus reset not shown");

  property p_suspend_set;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    !HOST_MODE_I && SUSPEND_ENTRY_I |=> suspend_q ##1 SUSPEND_O;
  endproperty
  a_suspend_set: assert property (p_suspend_set) else $error("suspend entry lost");

  property p_suspend_clr;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    INTR_REG_READ_I && !SUSPEND_ENTRY_I && !(HOST_MODE_I && wr_pwr_reg) |=> !suspend_q;
  endproperty
  a_suspend_clr: assert property (p_suspend_clr) else $error("suspend not cleared");

  property p_rsvd_bits;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    rd_en && rd_idx == 3'h1 |=> RDATA_O[5:4] == 2'h2;
  endproperty
  a_rsvd_bits: assert property (p_rsvd_bits) else $error("reserved field wrong");

  c_zero_len: cover property (@(posedge CLK_SYS_I) TX_O.send_zero_len);
  c_send_after_sof: cover property (@(posedge CLK_SYS_I)
    tx_state_q == ST_WAIT_SOF ##1 tx_state_q == ST_ARMED ##[1:50] TX_O.send_packet);
  c_irq: cover property (@(posedge CLK_SYS_I) $rose(IRQ_O));
  c_suspend_race: cover property (@(posedge CLK_SYS_I) SUSPEND_ENTRY_I && INTR_REG_READ_I);

endmodule : usbap_ctrl

// file: verification/usbap_link_model.sv
// Purpose: Far-side bus partner driving tokens, SOF, bus reset and suspend
// Assumes: Each event except the bus reset level is one clock long, launched just after a rising edge
// Notes: Idle token address is inverted so a stale one never matches
`timescale 1ns/1ps
module usbap_link_model (
  // Clock
  input wire logic clk_i,
  // Events to the block
  output usbap_pkg::usbap_token_t tok_o,
  output logic sof_o,
  output logic rdy_o,
  output logic rst_o,
  output logic susp_o
);
  initial begin
    tok_o = '0;
    sof_o = 0;
    rdy_o = 0;
    rst_o = 0;
    susp_o = 0;
  end
  task automatic tok(input logic in, input logic iso, input logic [6:0] a);
    @(posedge clk_i);
    tok_o <= {1'b1, in, iso, a};
    @(posedge clk_i);
    tok_o <= {3'h0, ~a};
  endtask : tok
  task automatic ev(input logic s, input logic p, input logic r, input logic iso);
    @(posedge clk_i);
    {sof_o, susp_o, rdy_o} <= {s, p, r};
    tok_o.iso <= iso;
    @(posedge clk_i);
    {sof_o, susp_o, rdy_o} <= 3'h0;
  endtask : ev
  // Reset signalling is a level held as long as the host wants
  task automatic lvl(input logic v);
    @(posedge clk_i);
    rst_o <= v;
  endtask : lvl
endmodule : usbap_link_model

// file: verification/usbap_ctrl_tb.sv
// Purpose: Self-checking bench for the USB address and power control block
// Assumes: Pins follow a register write one edge after the bus answer
// Notes: Bus answers are queued by the driver and compared by a monitor
`timescale 1ns/1ps
module usbap_ctrl_tb;
  logic clk = 0;
  logic RESET_N_I = 0;
  logic [11:0] AWADDR_I = '0;
  logic [11:0] ARADDR_I = '0;
  logic [31:0] WDATA_I = '0;
  logic [3:0] WSTRB_I = 4'hf;
  logic AWVALID_I = 0, WVALID_I = 0, BREADY_I = 0, ARVALID_I = 0, RREADY_I = 0;
  logic HOST_MODE_I = 0, INTR_REG_READ_I = 0;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
  logic [1:0] BRESP_O, RRESP_O;
  logic [31:0] RDATA_O;
  logic BUS_RESET_PIN_I, SUSPEND_ENTRY_I, SOF_SEEN_I, TRANSMIT_PACKET_READY_I;
  usbap_pkg::usbap_token_t TOKEN_I;
  usbap_pkg::usbap_tx_t TX_O;
  logic [6:0] BUS_FUNCTION_ADDRESS_O, fa;
  logic DP_OE_O, DM_OE_O, BUS_RESET_DRIVE_O, RESUME_DRIVE_O, SUSPEND_O;
  logic TRANSCEIVER_POWER_DOWN_O, IRQ_O;
  int errors = 0;
  int num_checks = 0;
  logic [33:0] exp_q[$];
  usbap_ctrl #(.AW(12)) u_usbap_ctrl (.CLK_SYS_I(clk), .RESET_N_I, .AWADDR_I, .AWVALID_I,
    .AWREADY_O, .WDATA_I, .WSTRB_I, .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I,
    .ARADDR_I, .ARVALID_I, .ARREADY_O, .RDATA_O, .RRESP_O, .RVALID_O, .RREADY_I,
    .HOST_MODE_I, .INTR_REG_READ_I, .BUS_RESET_PIN_I, .SUSPEND_ENTRY_I, .SOF_SEEN_I,
    .TRANSMIT_PACKET_READY_I, .TOKEN_I, .TX_O, .BUS_FUNCTION_ADDRESS_O, .DP_OE_O, .DM_OE_O,
    .BUS_RESET_DRIVE_O, .RESUME_DRIVE_O, .SUSPEND_O, .TRANSCEIVER_POWER_DOWN_O, .IRQ_O);
  usbap_link_model u_usbap_link_model (.clk_i(clk), .tok_o(TOKEN_I), .sof_o(SOF_SEEN_I),
    .rdy_o(TRANSMIT_PACKET_READY_I), .rst_o(BUS_RESET_PIN_I), .susp_o(SUSPEND_ENTRY_I));
  always #4 clk = ~clk;
  task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    @(posedge clk);
    AWADDR_I <= a;
    WDATA_I <= {24'($urandom), d};
    {AWVALID_I, WVALID_I, BREADY_I} <= 3'h7;
    fork
      begin
        do @(posedge clk); while (AWREADY_O !== 1'b1);
        AWVALID_I <= 0;
      end
      begin
        do @(posedge clk); while (WREADY_O !== 1'b1);
        WVALID_I <= 0;
      end
    join
    do @(posedge clk); while (BVALID_O !== 1'b1);
    BREADY_I <= 0;
    #1;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    exp_q.push_back({r, 24'h0, d});
    @(posedge clk);
    ARADDR_I <= a;
    {ARVALID_I, RREADY_I} <= 2'h3;
    do @(posedge clk); while (ARREADY_O !== 1'b1);
    ARVALID_I <= 0;
    do @(posedge clk); while (RVALID_O !== 1'b1);
    RREADY_I <= 0;
  endtask : rd
  task automatic tk(input logic iso, input logic [6:0] a, input logic [2:0] e);
    u_usbap_link_model.tok(1'b1, iso, a);
    #1 chk("tx", TX_O, e);
  endtask : tk
  always @(posedge clk) begin
    if (BVALID_O === 1'b1 && BREADY_I === 1'b1) begin
      chk("bresp", {BRESP_O, 32'h0}, exp_q.pop_front());
    end
    if (RVALID_O === 1'b1 && RREADY_I === 1'b1) begin
      chk("rd", {RRESP_O, RDATA_O}, exp_q.pop_front());
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  // Whole run is well under two thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    summarize();
  end
  initial begin
    void'($urandom(97155));
    repeat (16) @(posedge clk);
    RESET_N_I <= 1;
    rd(12'h000, 8'h00, 2'h0);
    rd(12'h004, 8'h20, 2'h0);
    wr(12'h010, 8'h55, 2'h2);
    rd(12'h010, 8'h00, 2'h2);
    $display("end reset test");
    fa = 7'($urandom);
    wr(12'h000, {1'b1, fa}, 2'h0);
    rd(12'h000, {1'b0, fa}, 2'h0);
    #1 chk("addr", BUS_FUNCTION_ADDRESS_O, fa);
    tk(1'b0, fa, 3'b001);
    tk(1'b0, fa ^ 7'h01, 3'b000);
    wr(12'h004, 8'hff, 2'h0);
    chk("pins", {DP_OE_O, DM_OE_O, TRANSCEIVER_POWER_DOWN_O, RESUME_DRIVE_O}, 4'hf);
    rd(12'h004, 8'he5, 2'h0);
    wr(12'h004, 8'h80, 2'h0);
    chk("off", {DP_OE_O, DM_OE_O, TRANSCEIVER_POWER_DOWN_O}, 3'h0);
    $display("end address test");
    u_usbap_link_model.ev(1'b0, 1'b0, 1'b1, 1'b1);
    tk(1'b1, fa, 3'b011);
    u_usbap_link_model.ev(1'b1, 1'b0, 1'b0, 1'b0);
    tk(1'b1, fa, 3'b101);
    u_usbap_link_model.ev(1'b0, 1'b0, 1'b1, 1'b0);
    tk(1'b0, fa, 3'b101);
    rd(12'h008, 8'h04, 2'h0);
    wr(12'h008, 8'h04, 2'h0);
    $display("end iso test");
    u_usbap_link_model.lvl(1'b1);
    repeat (4) @(posedge clk);
    rd(12'h004, 8'ha8, 2'h0);
    rd(12'h008, 8'h02, 2'h0);
    #1 chk("irq masked", IRQ_O, 1'b0);
    wr(12'h00c, 8'h02, 2'h0);
    chk("irq", IRQ_O, 1'b1);
    wr(12'h008, 8'h02, 2'h0);
    chk("irq clr", IRQ_O, 1'b0);
    u_usbap_link_model.lvl(1'b0);
    $display("end bus reset test");
    u_usbap_link_model.ev(1'b0, 1'b1, 1'b0, 1'b0);
    @(posedge clk);
    #1 chk("susp", SUSPEND_O, 1'b1);
    rd(12'h004, 8'ha2, 2'h0);
    @(posedge clk);
    INTR_REG_READ_I <= 1;
    @(posedge clk);
    INTR_REG_READ_I <= 0;
    rd(12'h004, 8'ha0, 2'h0);
    u_usbap_link_model.ev(1'b0, 1'b1, 1'b0, 1'b0);
    wr(12'h004, 8'ha4, 2'h0);
    chk("resume", RESUME_DRIVE_O, 1'b1);
    rd(12'h004, 8'ha4, 2'h0);
    $display("end suspend test");
    @(posedge clk);
    HOST_MODE_I <= 1;
    wr(12'h004, 8'h0c, 2'h0);
    chk("drv", {BUS_RESET_DRIVE_O, DP_OE_O, RESUME_DRIVE_O}, 3'h7);
    rd(12'h004, 8'h2c, 2'h0);
    wr(12'h004, 8'h02, 2'h0);
    wr(12'h004, 8'h01, 2'h0);
    rd(12'h004, 8'h23, 2'h0);
    #1 chk("pd", {TRANSCEIVER_POWER_DOWN_O, BUS_RESET_DRIVE_O, RESUME_DRIVE_O}, 3'h4);
    tk(1'b0, fa, 3'b000);
    $display("end host test");
    summarize();
  end
endmodule : usbap_ctrl_tb
